// [inc/cfot_pkg.sv]
// Constants and types for the current fault latch and charge overtemperature block.
// Assumes a 40 MHz system clock and an APB slave with 8-bit byte addresses.
package cfot_pkg;

    // Clock and time base
    localparam int CLK_HZ = 40_000_000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam int CYCLES_PER_US = CLK_HZ / HZ_PER_MHZ;
    localparam int US_PER_S = 1_000_000;
    localparam logic [7:0] RETRY_WINDOW_S = 8'h05;

    // Register byte offsets
    localparam logic [7:0] ADDR_SC_DELAY = 8'h00;
    localparam logic [7:0] ADDR_LATCH_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_RECOVERY = 8'h08;
    localparam logic [7:0] ADDR_OTC_THR = 8'h0c;
    localparam logic [7:0] ADDR_CHARGE_OVERTEMP_DELAY_CFG = 8'h10;
    localparam logic [7:0] ADDR_OTC_REC = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // Field widths
    localparam int SC_DELAY_W = 4;
    localparam int LATCH_W = 3;

    // Reset values
    localparam logic [3:0] RST_SC_DELAY = 4'h1;
    localparam logic [2:0] RST_LATCH_LIMIT = 3'h0;
    localparam logic [7:0] RST_RECOVERY = 8'h05;
    localparam logic [7:0] RST_OTC_THR = 8'h37;
    localparam logic [7:0] RST_CHARGE_OVERTEMP_DELAY_CFG = 8'h0f;
    localparam logic [7:0] RST_OTC_REC = 8'h3f;

    // Short-circuit delay per code in microseconds; codes above the last clamp
    localparam logic [3:0] SC_MAX_CODE = 4'ha;
    localparam logic [12:0] SC_DELAY_US [0:10] = '{
        13'd0, 13'd15, 13'd31, 13'd61, 13'd122, 13'd244,
        13'd488, 13'd977, 13'd1953, 13'd3906, 13'd7797};

    // Retries before latching per latch limit code; code 0 never latches
    localparam logic [7:0] RETRY_LIMIT [0:7] = '{
        8'd0, 8'd2, 8'd4, 8'd8, 8'd16, 8'd32, 8'd48, 8'd96};

    typedef struct packed {
        logic [3:0] sc_delay;
        logic [2:0] latch_limit;
        logic [7:0] recovery_s;
        logic [7:0] otc_thr;
        logic [7:0] charge_overtemp_delay_cfg;
        logic [7:0] otc_rec;
    } cfot_cfg_s;

    // Status register image, bit 0 upward: retry count, tripped, latched, otc fault
    typedef struct packed {
        logic otc_fault;
        logic latched;
        logic tripped;
        logic [7:0] retry_cnt;
    } cfot_status_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRIP = 3'b010,
        ST_LATCH = 3'b100
    } cfot_state_e;

endpackage

// [hw/cfot_top.sv]
// Current protection retry/latch/recovery and charge overtemperature detector.
// Assumes asynchronous comparator inputs and a thermistor sample from same-clock logic,
// one valid strobe per periodic sample interval.
//
// Operation
// - Short-circuit fault waits the delay chosen by a 4-bit code; code 0 fastest.
// - Latch limit code 1..7 allows 2,4,8,16,32,48,96 retries before latching.
// - Latch limit code 0 never latches the FETs off.
// - One retry count serves all current faults; at the limit FETs stay off.
// - No retrigger within five seconds after recovery clears the retry count.
// - A tripped current protection recovers after the programmed 1..255 seconds.
// - Recovery time zero disables automatic recovery.
// - Charge overtemperature detected when thermistor sample is below the threshold.
// - Overtemperature fault only after persisting the programmed sample intervals.
// - Overtemperature fault clears when the sample rises above the recovery threshold.
`timescale 1ns/1ps

module cfot_top #(
    parameter int US_PER_SECOND = cfot_pkg::US_PER_S
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic short_circuit_comparator,
    input wire logic discharge_overcurrent_fault_one,
    input wire logic discharge_overcurrent_fault_two,
    input wire logic charge_overcurrent_fault,
    input wire logic [7:0] thermistor_sense_pin,
    input wire logic thermistor_sample_valid,
    output logic discharge_short_circuit_fault,
    output logic charge_overtemp_fault,
    output logic discharge_fet_enable,
    output logic charge_fet_enable
);

    function automatic logic [12:0] sc_delay_us(input logic [3:0] code);
        logic [3:0] c;
        c = (code > cfot_pkg::SC_MAX_CODE) ? cfot_pkg::SC_MAX_CODE : code;
        return cfot_pkg::SC_DELAY_US[c];
    endfunction

    function automatic logic reg_hit(input logic [7:0] addr);
        return addr == cfot_pkg::ADDR_SC_DELAY || addr == cfot_pkg::ADDR_LATCH_LIMIT
            || addr == cfot_pkg::ADDR_RECOVERY || addr == cfot_pkg::ADDR_OTC_THR
            || addr == cfot_pkg::ADDR_CHARGE_OVERTEMP_DELAY_CFG || addr == cfot_pkg::ADDR_OTC_REC
            || addr == cfot_pkg::ADDR_STATUS;
    endfunction

    logic rst_q1;
    logic rst_n;
    logic [3:0] in_q1;
    logic [3:0] in_q2;
    cfot_pkg::cfot_cfg_s cfg;
    cfot_pkg::cfot_status_s status;
    cfot_pkg::cfot_state_e state;
    logic [5:0] us_div;
    logic us_tick;
    logic [19:0] sec_div;
    logic sec_tick;
    logic [7:0] sec_cnt;
    logic [12:0] sc_us_cnt;
    logic sc_live;
    logic sc_qual;
    logic cur_fault;
    logic [7:0] retry_cnt;
    logic [7:0] next_retry;
    logic [7:0] retry_lim;
    logic window_active;
    logic window_expire;
    logic trip_now;
    logic recover_now;
    logic trip_is_charge;
    logic [7:0] otc_cnt;
    logic apb_wr;

    // Reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // Comparator and fault inputs cross in through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_q1 <= 4'h0;
            in_q2 <= 4'h0;
        end else begin
            in_q1 <= {charge_overcurrent_fault, discharge_overcurrent_fault_two,
                      discharge_overcurrent_fault_one, short_circuit_comparator};
            in_q2 <= in_q1;
        end
    end

    // Microsecond and second time base; the second divider restarts on each
    // trip or recovery so that recovery and window times are never more than 1 us short
    assign us_tick = (us_div == 6'(cfot_pkg::CYCLES_PER_US - 1));
    assign sec_tick = us_tick && (sec_div == 20'(US_PER_SECOND - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            us_div <= 6'h00;
        end else begin
            us_div <= us_tick ? 6'h00 : us_div + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_div <= 20'h00000;
        end else if (trip_now || recover_now || sec_tick) begin
            sec_div <= 20'h00000;
        end else if (us_tick) begin
            sec_div <= sec_div + 20'h00001;
        end
    end

    // Short-circuit qualification delay
    assign sc_live = in_q2[0];
    // One extra tick: the free-running tick may land just after the comparator
    // rises, so a count of exactly the delay could qualify up to 1 us early
    assign sc_qual = sc_live && (cfg.sc_delay == 4'h0
                     || sc_us_cnt > sc_delay_us(cfg.sc_delay));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc_us_cnt <= 13'h0000;
        end else if (!sc_live) begin
            sc_us_cnt <= 13'h0000;
        end else if (us_tick && !sc_qual) begin
            sc_us_cnt <= sc_us_cnt + 13'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            discharge_short_circuit_fault <= 1'b0;
        end else begin
            discharge_short_circuit_fault <= sc_qual;
        end
    end

    // Retry, latch and recovery sequencing shared by all current faults
    assign cur_fault = sc_qual || (|in_q2[3:1]);
    assign retry_lim = cfot_pkg::RETRY_LIMIT[cfg.latch_limit];
    assign next_retry = (retry_cnt == 8'hff) ? retry_cnt : retry_cnt + 8'h01;
    assign trip_now = (state == cfot_pkg::ST_IDLE) && cur_fault;
    assign recover_now = (state == cfot_pkg::ST_TRIP) && (cfg.recovery_s != 8'h00)
                         && (sec_cnt >= cfg.recovery_s);
    assign window_expire = window_active && (state == cfot_pkg::ST_IDLE) && !cur_fault
                           && (sec_cnt == cfot_pkg::RETRY_WINDOW_S);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cfot_pkg::ST_IDLE;
        end else begin
            case (state)
                cfot_pkg::ST_IDLE: begin
                    if (trip_now && window_active && retry_lim != 8'h00
                        && next_retry >= retry_lim) begin
                        state <= cfot_pkg::ST_LATCH;
                    end else if (trip_now) begin
                        state <= cfot_pkg::ST_TRIP;
                    end
                end
                cfot_pkg::ST_TRIP: begin
                    if (recover_now) begin
                        state <= cfot_pkg::ST_IDLE;
                    end
                end
                cfot_pkg::ST_LATCH: state <= cfot_pkg::ST_LATCH;
                default: state <= cfot_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt <= 8'h00;
        end else if (trip_now && window_active) begin
            retry_cnt <= next_retry;
        end else if (window_expire) begin
            retry_cnt <= 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_active <= 1'b0;
        end else if (recover_now) begin
            window_active <= 1'b1;
        end else if (window_expire || trip_now) begin
            window_active <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt <= 8'h00;
        end else if (trip_now || recover_now) begin
            sec_cnt <= 8'h00;
        end else if (sec_tick && sec_cnt != 8'hff) begin
            sec_cnt <= sec_cnt + 8'h01;
        end
    end

    // A trip on charge overcurrent alone opens the charge FET, one with any discharge fault the discharge FET
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_is_charge <= 1'b0;
        end else if (trip_now) begin
            trip_is_charge <= in_q2[3] && !sc_qual && !(|in_q2[2:1]);
        end
    end

    // Charge overtemperature detection on each thermistor sample
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_overtemp_fault <= 1'b0;
            otc_cnt <= 8'h00;
        end else if (thermistor_sample_valid) begin
            if (charge_overtemp_fault) begin
                otc_cnt <= 8'h00;
                if (thermistor_sense_pin > cfg.otc_rec) begin
                    charge_overtemp_fault <= 1'b0;
                end
            end else if (thermistor_sense_pin < cfg.otc_thr) begin
                if (otc_cnt >= cfg.charge_overtemp_delay_cfg) begin
                    charge_overtemp_fault <= 1'b1;
                    otc_cnt <= 8'h00;
                end else begin
                    otc_cnt <= otc_cnt + 8'h01;
                end
            end else begin
                otc_cnt <= 8'h00;
            end
        end
    end

    assign discharge_fet_enable = (state == cfot_pkg::ST_IDLE)
                                  || (state == cfot_pkg::ST_TRIP && trip_is_charge);
    assign charge_fet_enable = !charge_overtemp_fault && ((state == cfot_pkg::ST_IDLE)
                               || (state == cfot_pkg::ST_TRIP && !trip_is_charge));

    // APB slave: no wait states, read data captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !reg_hit(paddr);
    assign apb_wr = psel && penable && pwrite && reg_hit(paddr);
    assign status = '{otc_fault: charge_overtemp_fault,
                      latched: state == cfot_pkg::ST_LATCH,
                      tripped: state == cfot_pkg::ST_TRIP,
                      retry_cnt: retry_cnt};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg.sc_delay <= cfot_pkg::RST_SC_DELAY;
            cfg.latch_limit <= cfot_pkg::RST_LATCH_LIMIT;
            cfg.recovery_s <= cfot_pkg::RST_RECOVERY;
            cfg.otc_thr <= cfot_pkg::RST_OTC_THR;
            cfg.charge_overtemp_delay_cfg <= cfot_pkg::RST_CHARGE_OVERTEMP_DELAY_CFG;
            cfg.otc_rec <= cfot_pkg::RST_OTC_REC;
        end else if (apb_wr) begin
            case (paddr)
                cfot_pkg::ADDR_SC_DELAY: cfg.sc_delay <= pwdata[cfot_pkg::SC_DELAY_W-1:0];
                cfot_pkg::ADDR_LATCH_LIMIT: cfg.latch_limit <= pwdata[cfot_pkg::LATCH_W-1:0];
                cfot_pkg::ADDR_RECOVERY: cfg.recovery_s <= pwdata[7:0];
                cfot_pkg::ADDR_OTC_THR: cfg.otc_thr <= pwdata[7:0];
                cfot_pkg::ADDR_CHARGE_OVERTEMP_DELAY_CFG: cfg.charge_overtemp_delay_cfg <= pwdata[7:0];
                cfot_pkg::ADDR_OTC_REC: cfg.otc_rec <= pwdata[7:0];
                default: cfg.sc_delay <= cfg.sc_delay;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                cfot_pkg::ADDR_SC_DELAY: prdata <= {28'h0000000, cfg.sc_delay};
                cfot_pkg::ADDR_LATCH_LIMIT: prdata <= {29'h00000000, cfg.latch_limit};
                cfot_pkg::ADDR_RECOVERY: prdata <= {24'h000000, cfg.recovery_s};
                cfot_pkg::ADDR_OTC_THR: prdata <= {24'h000000, cfg.otc_thr};
                cfot_pkg::ADDR_CHARGE_OVERTEMP_DELAY_CFG: prdata <= {24'h000000, cfg.charge_overtemp_delay_cfg};
                cfot_pkg::ADDR_OTC_REC: prdata <= {24'h000000, cfg.otc_rec};
                cfot_pkg::ADDR_STATUS: prdata <= {21'h000000, status};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sc_delay_held_a: assert property (
        sc_qual |-> sc_us_cnt >= sc_delay_us(cfg.sc_delay))
        else $error("short-circuit fault qualified before its delay");
    sc_fast_trip_a: assert property (
        (state == cfot_pkg::ST_IDLE && sc_live && cfg.sc_delay == 4'h0)
        |=> state != cfot_pkg::ST_IDLE)
        else $error("fastest short-circuit code did not trip at once");
    latch_at_limit_a: assert property (
        $rose(state == cfot_pkg::ST_LATCH) |-> retry_cnt == retry_lim && retry_lim != 8'h00)
        else $error("latched with retry count not at the limit");
    no_latch_zero_a: assert property (
        (cfg.latch_limit == 3'h0 && state != cfot_pkg::ST_LATCH)
        |=> state != cfot_pkg::ST_LATCH)
        else $error("latched with latch limit code zero");
    latch_holds_a: assert property (
        state == cfot_pkg::ST_LATCH
        |=> state == cfot_pkg::ST_LATCH && !discharge_fet_enable && !charge_fet_enable)
        else $error("latched state released or FETs enabled");
    window_clear_a: assert property (
        window_expire |=> retry_cnt == 8'h00 && !window_active)
        else $error("retry count not cleared at window end");
    no_early_recover_a: assert property (
        (state == cfot_pkg::ST_TRIP && sec_cnt < cfg.recovery_s) |=> state != cfot_pkg::ST_IDLE)
        else $error("current protection recovered early");
    no_auto_recover_a: assert property (
        (state == cfot_pkg::ST_TRIP && cfg.recovery_s == 8'h00) |=> state == cfot_pkg::ST_TRIP)
        else $error("recovered with recovery time zero");
    retry_bump_a: assert property (
        (trip_now && window_active && retry_cnt != 8'hff) |=> retry_cnt == $past(retry_cnt) + 8'h01)
        else $error("retry count not incremented on retrigger");
    otc_set_a: assert property (
        (thermistor_sample_valid && !charge_overtemp_fault && thermistor_sense_pin < cfg.otc_thr
         && otc_cnt == cfg.charge_overtemp_delay_cfg) |=> charge_overtemp_fault)
        else $error("overtemperature fault not set after delay");
    otc_wait_a: assert property (
        (!charge_overtemp_fault && otc_cnt < cfg.charge_overtemp_delay_cfg) |=> !charge_overtemp_fault)
        else $error("overtemperature fault set before delay expired");
    otc_clear_a: assert property (
        (thermistor_sample_valid && charge_overtemp_fault && thermistor_sense_pin > cfg.otc_rec)
        |=> !charge_overtemp_fault)
        else $error("overtemperature fault not cleared above recovery");
    otc_restart_a: assert property (
        (thermistor_sample_valid && !charge_overtemp_fault && thermistor_sense_pin >= cfg.otc_thr)
        |=> otc_cnt == 8'h00)
        else $error("overtemperature delay not restarted");

    latch_seen_c: cover property ($rose(state == cfot_pkg::ST_LATCH));
    recover_seen_c: cover property (recover_now);
    window_seen_c: cover property (window_expire);
    otc_cycle_c: cover property ($fell(charge_overtemp_fault));

endmodule

// [tb/cfot_analog_model.sv]
// Far-side model: current comparators and the periodic thermistor sampler.
// Assumes the bench sets fault levels and the temperature code on the same clock.
`timescale 1ns/1ps

module cfot_analog_model #(
    parameter int SAMPLE_GAP = 20
) (
    input wire logic clk,
    input wire logic [3:0] fault_req,
    input wire logic [7:0] temp_code,
    output logic short_circuit_comparator,
    output logic discharge_overcurrent_fault_one,
    output logic discharge_overcurrent_fault_two,
    output logic charge_overcurrent_fault,
    output logic [7:0] thermistor_sense_pin,
    output logic thermistor_sample_valid
);
    int gap_cnt;

    initial begin
        gap_cnt = 0;
        {short_circuit_comparator, discharge_overcurrent_fault_one} = 2'b00;
        {discharge_overcurrent_fault_two, charge_overcurrent_fault} = 2'b00;
        thermistor_sense_pin = 8'h00;
        thermistor_sample_valid = 1'b0;
    end

    always @(posedge clk) begin
        charge_overcurrent_fault <= fault_req[0];
        discharge_overcurrent_fault_one <= fault_req[1];
        discharge_overcurrent_fault_two <= fault_req[2];
        short_circuit_comparator <= fault_req[3];
    end

    // One sample per interval; between samples the code toggles so stale data never looks valid
    always @(posedge clk) begin
        gap_cnt <= (gap_cnt == SAMPLE_GAP - 1) ? 0 : gap_cnt + 1;
        thermistor_sample_valid <= (gap_cnt == 0);
        thermistor_sense_pin <= (gap_cnt == 0) ? temp_code : ~thermistor_sense_pin;
    end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the current fault latch and charge overtemperature block.
// Assumes one second is shortened to SEC_US microseconds at a 40 MHz clock.
`timescale 1ns/1ps

module testbench;
    localparam int SEC_US = 20;
    localparam int SEC = SEC_US * 40;
    localparam int LIMIT = 60000;
    localparam logic [7:0] STAT = 8'h18;
    localparam logic [31:0] RST[6] = '{32'h01, 32'h00, 32'h05, 32'h37, 32'h0f, 32'h3f};
    localparam logic [31:0] MSK[6] = '{32'h0f, 32'h07, 32'hff, 32'hff, 32'hff, 32'hff};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] flt_req = 4'h0;
    logic [7:0] temp_code = 8'h80;
    logic sc_cmp, od1, od2, oc_chg, smp_vld, sc_flt, otc_flt, dis_en, chg_en;
    logic [7:0] smp_code;
    logic [31:0] q;
    logic [31:0] d;
    logic e;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    cfot_top #(.US_PER_SECOND(SEC_US)) cfot_top_inst (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .short_circuit_comparator(sc_cmp), .discharge_overcurrent_fault_one(od1),
        .discharge_overcurrent_fault_two(od2), .charge_overcurrent_fault(oc_chg),
        .thermistor_sense_pin(smp_code), .thermistor_sample_valid(smp_vld),
        .discharge_short_circuit_fault(sc_flt), .charge_overtemp_fault(otc_flt),
        .discharge_fet_enable(dis_en), .charge_fet_enable(chg_en));

    cfot_analog_model cfot_analog_model_inst (
        .clk(clk), .fault_req(flt_req), .temp_code(temp_code),
        .short_circuit_comparator(sc_cmp), .discharge_overcurrent_fault_one(od1),
        .discharge_overcurrent_fault_two(od2), .charge_overcurrent_fault(oc_chg),
        .thermistor_sense_pin(smp_code), .thermistor_sample_valid(smp_vld));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi);
        n_tests++;
        if (v < lo || v > hi) begin
            mismatches++;
            $display("mismatch at %0t: %0d cycles outside %0d..%0d", $time, v, lo, hi);
        end
    endtask

    // Setup then access; released only after pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                          input logic eerr);
        apb(1'b0, a, 32'h0);
        chk(q & m, exp);
        chk(e, eerr);
    endtask

    function automatic logic pick(input int sel);
        return sel == 0 ? chg_en : (sel == 1 ? dis_en : sc_flt);
    endfunction

    task automatic wait_sig(input int sel, input logic lvl, input int max);
        n = 0;
        while (pick(sel) !== lvl && n < max) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic samples(input int k);
        repeat (k) begin
            @(posedge clk);
            while (smp_vld !== 1'b1) begin
                @(posedge clk);
            end
        end
        @(posedge clk);
    endtask

    function automatic int dly_us(input int c);
        int t[4] = '{0, 15, 31, 61};
        return t[c];
    endfunction

    initial begin
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == LIMIT) begin
                mismatches++;
                $display("mismatch at %0t: run limit reached", $time);
                close_out();
            end
        end
    end

    initial begin
        void'($urandom(41468));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'(4 * i), RST[i], 32'hffffffff, 1'b0);
        end
        rd_chk(8'h1c, 32'h0, 32'hffffffff, 1'b1);
        for (int i = 0; i < 12; i++) begin
            d = $urandom;
            apb(1'b1, 8'(4 * (i % 6)), d);
            rd_chk(8'(4 * (i % 6)), d & MSK[i % 6], 32'hffffffff, 1'b0);
        end
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h0c, 32'h37);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h14, 32'h3f);
        // Overtemperature: equal is not below, a good sample restarts, hysteresis on clear
        samples(2);
        temp_code <= 8'h37;
        samples(4);
        chk(otc_flt, 1'b0);
        temp_code <= 8'h36;
        samples(2);
        chk(otc_flt, 1'b0);
        temp_code <= 8'h60;
        samples(1);
        temp_code <= 8'h36;
        samples(2);
        chk(otc_flt, 1'b0);
        samples(1);
        chk({otc_flt, chg_en}, 2'b10);
        temp_code <= 8'h3f;
        samples(2);
        chk(otc_flt, 1'b1);
        temp_code <= 8'h40;
        samples(1);
        chk({otc_flt, chg_en}, 2'b01);
        // Every current fault in turn shares one retry count
        for (int b = 0; b < 4; b++) begin
            flt_req[b] <= 1'b1;
            wait_sig(b == 0 ? 0 : 1, 1'b0, 700);
            chk_rng(n, b == 3 ? 600 : 1, (b == 3 ? 600 : 1) + 50);
            chk({chg_en, dis_en}, b == 0 ? 2'b01 : 2'b10);
            flt_req[b] <= 1'b0;
            wait_sig(b == 0 ? 0 : 1, 1'b1, 2 * SEC);
            chk_rng(n, SEC - 60, SEC + 60);
        end
        rd_chk(STAT, 32'h3, 32'h3ff, 1'b0);
        repeat (5 * SEC + 100) @(posedge clk);
        rd_chk(STAT, 32'h0, 32'hff, 1'b0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'h00, 32'(c));
            flt_req[3] <= 1'b1;
            wait_sig(2, 1'b1, 3000);
            chk_rng(n, dly_us(c) * 40, dly_us(c) * 40 + 50);
            flt_req[3] <= 1'b0;
            wait_sig(1, 1'b1, 2 * SEC);
        end
        apb(1'b1, 8'h00, 32'h2);
        flt_req[3] <= 1'b1;
        repeat (600) @(posedge clk);
        flt_req[3] <= 1'b0;
        repeat (1000) @(posedge clk);
        chk({sc_flt, dis_en}, 2'b01);
        // Limit code 1: latch on the second retry, both FETs held off
        repeat (5 * SEC + 100) @(posedge clk);
        apb(1'b1, 8'h04, 32'h1);
        flt_req[0] <= 1'b1;
        repeat (SEC * 3 / 2) @(posedge clk);
        rd_chk(STAT, 32'h0, 32'h200, 1'b0);
        repeat (SEC) @(posedge clk);
        flt_req[0] <= 1'b0;
        repeat (2 * SEC) @(posedge clk);
        chk({chg_en, dis_en}, 2'b00);
        rd_chk(STAT, 32'h200, 32'h200, 1'b0);
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // Recovery time zero never recovers
        apb(1'b1, 8'h08, 32'h0);
        flt_req[0] <= 1'b1;
        repeat (10) @(posedge clk);
        flt_req[0] <= 1'b0;
        repeat (3 * SEC) @(posedge clk);
        chk(chg_en, 1'b0);
        rd_chk(STAT, 32'h100, 32'h100, 1'b0);
        close_out();
    end
endmodule
